// ===== include/pkh_map.vh
// Register indices, field positions, reset values and coding constants of the packet handler.
`ifndef PKH_MAP_VH
`define PKH_MAP_VH

// Register indices; byte address is four times the index.
`define PKH_IDX_CFG1      8'h30
`define PKH_IDX_CFG2      8'h31
`define PKH_IDX_LEN_LO    8'h32
`define PKH_IDX_OWN_ID    8'h33
`define PKH_IDX_GRP_ID    8'h34
`define PKH_IDX_THRESH    8'h35
`define PKH_IDX_IRQ_ST    8'h38
`define PKH_IDX_IRQ_MASK  8'h39
`define PKH_IDX_FIFO      8'h3A
`define PKH_IDX_STATUS    8'h3B

// Field positions.
`define PKH_F_FORMAT      7
`define PKH_F_CODE_HI     6
`define PKH_F_CODE_LO     5
`define PKH_F_CRC_EN      4
`define PKH_F_KEEP        3
`define PKH_F_ADDR_HI     2
`define PKH_F_ADDR_LO     1
`define PKH_F_VARIANT     0
`define PKH_F_STYLE       6
`define PKH_F_COMPAT      5
`define PKH_F_BEACON      3
`define PKH_F_LEN_HI      2
`define PKH_F_TRIG        7
`define PKH_F_LIMIT_HI    5

// Reset values and writable masks.
`define PKH_RST_CFG1      8'h90
`define PKH_RST_CFG2      8'h40
`define PKH_RST_LEN_LO    8'h40
`define PKH_RST_ID        8'h00
`define PKH_RST_THRESH    8'h8F
`define PKH_WMASK_CFG2    8'h7F
`define PKH_WMASK_THRESH  8'hBF

// Field encodings.
`define PKH_CODE_MANCH    2'b01
`define PKH_CODE_WHITE    2'b10
`define PKH_FILT_OWN      2'b01
`define PKH_FILT_GROUP    2'b10

// Interrupt bit positions.
`define PKH_IRQ_BODY      0
`define PKH_IRQ_SENT      1
`define PKH_IRQ_CRC_OK    2
`define PKH_IRQ_OVERRUN   3

// Checksum and scrambler constants.
`define PKH_CRC_POLY_STD  16'h1021
`define PKH_CRC_POLY_ALT  16'h8005
`define PKH_CRC_INIT_STD  16'hFFFF
`define PKH_CRC_INIT_ALT  16'hFFFF
`define PKH_CRC_XOR_STD   16'hFFFF
`define PKH_CRC_XOR_ALT   16'h0000
`define PKH_PN_TAPS_STD   9'h021
`define PKH_PN_TAPS_ALT   9'h011
`define PKH_PN_SEED       9'h1FF

// FIFO depth is two to this power.
`define PKH_FIFO_AW       6

`endif

// ===== logic/pkh_coder.v
// Per-byte line coding, scrambling and checksum update for the packet handler.
`timescale 1ns/1ps
`include "pkh_map.vh"

module pkh_coder
(
  // Byte and direction
  input  wire [15:0] din_in,
  input  wire        decode_in,
  // Coding selection
  input  wire [1:0]  coding_in,
  input  wire        variant_in,
  // Running state
  input  wire [15:0] crc_in,
  input  wire [8:0]  lfsr_in,
  // Results
  output wire [15:0] word_out,
  output wire [7:0]  plain_out,
  output wire [15:0] crc_out,
  output wire [8:0]  lfsr_out
);

function [15:0] manch_enc(input [7:0] b);
  integer i;
  begin
    manch_enc = 16'h0000;
    for (i = 0; i < 8; i = i + 1)
    begin
      manch_enc[2*i+1] = b[i];
      manch_enc[2*i]   = ~b[i];
    end
  end
endfunction

function [7:0] manch_dec(input [15:0] w);
  integer i;
  begin
    manch_dec = 8'h00;
    for (i = 0; i < 8; i = i + 1)
      manch_dec[i] = w[2*i+1];
  end
endfunction

// Returns the advanced state above eight scrambler bits.
function [16:0] pn_step(input [8:0] s, input [8:0] taps);
  integer i;
  reg     [8:0] st;
  reg     [7:0] pn;
  begin
    st = s;
    pn = 8'h00;
    for (i = 0; i < 8; i = i + 1)
    begin
      pn[i] = st[0];
      st    = {^(st & taps), st[8:1]};
    end
    pn_step = {st, pn};
  end
endfunction

function [15:0] crc_step(input [15:0] c, input [7:0] b, input [15:0] poly);
  integer i;
  reg     [15:0] r;
  begin
    r = c;
    for (i = 7; i >= 0; i = i - 1)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? poly : 16'h0000);
    crc_step = r;
  end
endfunction

wire        manch  = (coding_in == `PKH_CODE_MANCH);
wire        whiten = (coding_in == `PKH_CODE_WHITE);
wire [16:0] pn     = pn_step(lfsr_in, variant_in ? `PKH_PN_TAPS_ALT : `PKH_PN_TAPS_STD);
wire [7:0]  line_b = manch ? manch_dec(din_in) : din_in[7:0];
wire [7:0]  rx_b   = whiten ? (line_b ^ pn[7:0]) : line_b;
wire [7:0]  tx_w   = whiten ? (din_in[7:0] ^ pn[7:0]) : din_in[7:0];

// Scrambling sits inside the Manchester layer so both directions undo in reverse order.
assign plain_out = decode_in ? rx_b : din_in[7:0];
assign word_out  = manch ? manch_enc(tx_w) : {8'h00, tx_w};
assign lfsr_out  = whiten ? pn[16:8] : lfsr_in;
assign crc_out   = crc_step(crc_in, plain_out,
                            variant_in ? `PKH_CRC_POLY_ALT : `PKH_CRC_POLY_STD);

endmodule

// ===== logic/pkh_packet_handler.v
// Packet handler: registers, byte FIFO and frame sequencing between host and modem.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "pkh_map.vh"
// Contract
// (RL1) Format bit: clear gives fixed frames, set gives variable frames with length byte.
// (RL2) Coding field: none, Manchester or whitening; applied on send, removed on receive.
// (RL3) Checksum enable appends a CRC on send and checks it on receive.
// (RL4) Bad CRC: flush and restart unless keep bit set, then keep and flag.
// (RL5) Address filter: all, own address only, or own or group address.
// (RL6) Variant bit picks standard or alternate checksum polynomial and scrambler.
// (RL7) Processing style bit: continuous bitstream when clear, packet engine when set.
// (RL8) Compatibility enable bit, reset clear, switches compatibility mode; neighbour reserved.
// (RL9) Beacon operation only applies with fixed-length frames.
// (RL10) Body length is eleven bits; low byte register resets to 0x40.
// (RL11) Fixed frames: exact body size; variable: receive maximum, ignored on send.
// (RL12) Send trigger: level above threshold when clear, non-empty when set.
// (RL13) Level flag while FIFO count is at least threshold plus one.
// (RL14) Sync length is size plus one, or exactly size in compatibility mode.

module pkh_packet_handler
(
  // Clock and reset
  input  wire        clk_sys_in,
  input  wire        arst_n_in,
  // AHB-Lite slave
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire        hready_in,
  input  wire [31:0] hwdata_in,
  output wire [31:0] hrdata_out,
  output wire        hreadyout_out,
  output wire        hresp_out,
  // Modem transmit side
  input  wire        tx_enable_in,
  input  wire        tx_ready_in,
  output wire        tx_valid_out,
  output wire        tx_wide_out,
  output wire [15:0] tx_data_out,
  // Modem receive side
  input  wire        rx_enable_in,
  input  wire        rx_start_in,
  input  wire        rx_valid_in,
  input  wire [15:0] rx_data_in,
  // Sync length and flags
  input  wire [2:0]  sync_size_in,
  output wire [3:0]  sync_len_out,
  output wire        buffer_level_out,
  output wire        buffer_empty_out,
  output wire        irq_out
);

localparam [3:0] ST_IDLE     = 4'h0;
localparam [3:0] ST_TX_LEN   = 4'h1;
localparam [3:0] ST_TX_BODY  = 4'h2;
localparam [3:0] ST_TX_CRCH  = 4'h3;
localparam [3:0] ST_TX_CRCL  = 4'h4;
localparam [3:0] ST_TX_END   = 4'h5;
localparam [3:0] ST_RX_LEN   = 4'h6;
localparam [3:0] ST_RX_BODY  = 4'h7;
localparam [3:0] ST_RX_CRCH  = 4'h8;
localparam [3:0] ST_RX_CRCL  = 4'h9;
localparam [6:0] FIFO_DEPTH  = 7'h40;

// ----
// Registers and configuration fields
// ----
reg  [7:0]  cfg1_ff;
reg  [7:0]  cfg2_ff;
reg  [7:0]  len_lo_ff;
reg  [7:0]  own_id_ff;
reg  [7:0]  grp_id_ff;
reg  [7:0]  thr_ff;
reg  [3:0]  irq_st_ff;
reg  [3:0]  irq_mask_ff;
reg         dp_wr_ff;
reg  [7:0]  dp_idx_ff;
reg  [31:0] hrdata_ff;
reg  [31:0] rd_val;

wire        frame_length_kind     = cfg1_ff[`PKH_F_FORMAT];
wire [1:0]  line_balance_coding   = cfg1_ff[`PKH_F_CODE_HI:`PKH_F_CODE_LO];
wire        checksum_enable       = cfg1_ff[`PKH_F_CRC_EN];
wire        keep_buffer_on_bad_check = cfg1_ff[`PKH_F_KEEP];
wire [1:0]  address_match_select  = cfg1_ff[`PKH_F_ADDR_HI:`PKH_F_ADDR_LO];
wire        checksum_scrambler_variant = cfg1_ff[`PKH_F_VARIANT];
wire        processing_style      = cfg2_ff[`PKH_F_STYLE];
wire        home_automation_compat = cfg2_ff[`PKH_F_COMPAT];
wire        beacon_enable         = cfg2_ff[`PKH_F_BEACON];
wire [10:0] body_length           = {cfg2_ff[`PKH_F_LEN_HI:0], len_lo_ff}; // RL10
wire        send_trigger_select   = thr_ff[`PKH_F_TRIG];
wire [6:0]  buffer_level_limit    = {1'b0, thr_ff[`PKH_F_LIMIT_HI:0]};

// ----
// FIFO storage and flags
// ----
reg  [7:0]  fifo_mem [0:FIFO_DEPTH-1];
reg  [6:0]  wr_ptr_ff;
reg  [6:0]  rd_ptr_ff;
reg  [6:0]  frame_rd_ff;

wire [6:0]  fill       = wr_ptr_ff - rd_ptr_ff;
wire        fifo_empty = (fill == 7'h00);
wire        fifo_full  = (fill == FIFO_DEPTH);
wire [7:0]  fifo_head  = fifo_mem[rd_ptr_ff[`PKH_FIFO_AW-1:0]];
wire        buffer_level_flag = (fill >= buffer_level_limit + 7'h01); // RL13
wire        buffer_empty_flag = fifo_empty;

// ----
// Bus decode
// ----
wire        ap       = hsel_in & htrans_in[1] & hready_in;
wire [7:0]  ap_idx   = haddr_in[9:2];
wire        host_pop = ap & ~hwrite_in & (ap_idx == `PKH_IDX_FIFO) & ~fifo_empty;
wire        host_push = dp_wr_ff & (dp_idx_ff == `PKH_IDX_FIFO);
wire        irq_wr   = dp_wr_ff & (dp_idx_ff == `PKH_IDX_IRQ_ST);

// ----
// Frame engine
// ----
reg  [3:0]  state_ff;
reg  [10:0] cnt_ff;
reg  [10:0] len_ff;
reg  [15:0] crc_ff;
reg  [8:0]  lfsr_ff;
reg  [7:0]  crc_hi_ff;
reg         tx_valid_ff;
reg         tx_wide_ff;
reg  [15:0] tx_data_ff;
reg  [3:0]  nxt_state;
reg  [10:0] nxt_cnt;
reg  [10:0] nxt_len;
reg  [15:0] nxt_crc;
reg  [8:0]  nxt_lfsr;
reg  [7:0]  nxt_crc_hi;
reg         nxt_tx_valid;
reg         nxt_tx_wide;
reg  [15:0] nxt_tx_data;
reg         eng_push;
reg         eng_pop;
reg  [7:0]  eng_data;
reg         flush;
reg         rewind;
reg  [3:0]  ev;

wire [15:0] cod_word;
wire [7:0]  cod_plain;
wire [15:0] cod_crc;
wire [8:0]  cod_lfsr;

wire        rx_side   = (state_ff >= ST_RX_LEN);
wire        slot_free = ~tx_valid_ff | tx_ready_in;
wire        manch     = (line_balance_coding == `PKH_CODE_MANCH);
wire [15:0] crc_init  = checksum_scrambler_variant ? `PKH_CRC_INIT_ALT : `PKH_CRC_INIT_STD;
wire [15:0] crc_fin   = crc_ff ^ (checksum_scrambler_variant ? `PKH_CRC_XOR_ALT
                                                               : `PKH_CRC_XOR_STD); // RL6
wire [7:0]  tx_byte   = (state_ff == ST_TX_CRCH) ? crc_fin[15:8] :
                        (state_ff == ST_TX_CRCL) ? crc_fin[7:0] : fifo_head;
wire        tx_go     = send_trigger_select ? ~buffer_empty_flag
                                            : (fill > buffer_level_limit); // RL12
wire        beacon_on = beacon_enable & ~frame_length_kind; // RL9

function addr_ok(input [1:0] sel, input [7:0] b, input [7:0] own, input [7:0] grp);
  begin
    case (sel)
      `PKH_FILT_OWN:   addr_ok = (b == own);
      `PKH_FILT_GROUP: addr_ok = (b == own) | (b == grp);
      default:         addr_ok = 1'b1;
    endcase
  end
endfunction

pkh_coder u_coder
(
  .din_in     (rx_side ? rx_data_in : {8'h00, tx_byte}),
  .decode_in  (rx_side),
  .coding_in  (line_balance_coding), // RL2
  .variant_in (checksum_scrambler_variant), // RL6
  .crc_in     (crc_ff),
  .lfsr_in    (lfsr_ff),
  .word_out   (cod_word),
  .plain_out  (cod_plain),
  .crc_out    (cod_crc),
  .lfsr_out   (cod_lfsr)
);

always @*
begin
  nxt_state    = state_ff;
  nxt_cnt      = cnt_ff;
  nxt_len      = len_ff;
  nxt_crc      = crc_ff;
  nxt_lfsr     = lfsr_ff;
  nxt_crc_hi   = crc_hi_ff;
  nxt_tx_valid = tx_valid_ff & ~tx_ready_in;
  nxt_tx_wide  = tx_wide_ff;
  nxt_tx_data  = tx_data_ff;
  eng_push     = 1'b0;
  eng_pop      = 1'b0;
  eng_data     = cod_plain;
  flush        = 1'b0;
  rewind       = 1'b0;
  ev           = 4'h0;
  case (state_ff)
    ST_IDLE:
    begin
      if (!processing_style) // RL7
      begin
        if (tx_enable_in & slot_free & ~fifo_empty)
        begin
          eng_pop      = 1'b1;
          nxt_tx_valid = 1'b1;
          nxt_tx_wide  = 1'b0;
          nxt_tx_data  = {8'h00, fifo_head};
        end
        if (rx_enable_in & rx_valid_in)
        begin
          eng_push = 1'b1;
          eng_data = rx_data_in[7:0];
        end
      end
      else if ((rx_enable_in & rx_start_in) | (~rx_enable_in & tx_enable_in & tx_go))
      begin
        nxt_crc  = crc_init;
        nxt_lfsr = `PKH_PN_SEED;
        nxt_cnt  = 11'h000;
        nxt_len  = body_length; // RL11
        if (rx_enable_in)
          nxt_state = frame_length_kind ? ST_RX_LEN : ST_RX_BODY; // RL1
        else
          nxt_state = frame_length_kind ? ST_TX_LEN : ST_TX_BODY; // RL1
      end
    end
    ST_TX_LEN, ST_TX_BODY:
    begin
      if ((state_ff == ST_TX_BODY) && (cnt_ff == len_ff))
        nxt_state = checksum_enable ? ST_TX_CRCH : ST_TX_END; // RL3
      else if (slot_free & ~fifo_empty)
      begin
        eng_pop      = 1'b1;
        nxt_tx_valid = 1'b1;
        nxt_tx_wide  = manch;
        nxt_tx_data  = cod_word;
        nxt_lfsr     = cod_lfsr;
        nxt_crc      = cod_crc;
        if (state_ff == ST_TX_LEN)
        begin
          // The length byte from the FIFO replaces the configured size.
          nxt_len   = {3'b000, fifo_head}; // RL11
          nxt_state = ST_TX_BODY;
        end
        else
          nxt_cnt = cnt_ff + 11'h001;
      end
    end
    ST_TX_CRCH, ST_TX_CRCL:
    begin
      if (slot_free)
      begin
        nxt_tx_valid = 1'b1;
        nxt_tx_wide  = manch;
        nxt_tx_data  = cod_word;
        nxt_lfsr     = cod_lfsr;
        nxt_state    = (state_ff == ST_TX_CRCH) ? ST_TX_CRCL : ST_TX_END; // RL3
      end
    end
    ST_TX_END:
    begin
      ev[`PKH_IRQ_SENT] = 1'b1;
      rewind    = beacon_on; // RL9
      nxt_state = ST_IDLE;
    end
    ST_RX_LEN:
    begin
      if (rx_valid_in)
      begin
        if ((cod_plain == 8'h00) || ({3'b000, cod_plain} > body_length)) // RL11
        begin
          flush     = 1'b1;
          nxt_state = ST_IDLE;
        end
        else
        begin
          eng_push  = 1'b1;
          nxt_crc   = cod_crc;
          nxt_lfsr  = cod_lfsr;
          nxt_len   = {3'b000, cod_plain};
          nxt_state = ST_RX_BODY;
        end
      end
    end
    ST_RX_BODY:
    begin
      if (cnt_ff == len_ff)
      begin
        nxt_state = checksum_enable ? ST_RX_CRCH : ST_IDLE; // RL3
        ev[`PKH_IRQ_BODY] = ~checksum_enable;
      end
      else if (rx_valid_in)
      begin
        if ((cnt_ff == 11'h000) &&
            !addr_ok(address_match_select, cod_plain, own_id_ff, grp_id_ff)) // RL5
        begin
          flush     = 1'b1;
          nxt_state = ST_IDLE;
        end
        else
        begin
          eng_push = 1'b1;
          nxt_crc  = cod_crc;
          nxt_lfsr = cod_lfsr;
          nxt_cnt  = cnt_ff + 11'h001;
        end
      end
    end
    ST_RX_CRCH:
    begin
      if (rx_valid_in)
      begin
        nxt_crc_hi = cod_plain;
        nxt_lfsr   = cod_lfsr;
        nxt_state  = ST_RX_CRCL;
      end
    end
    ST_RX_CRCL:
    begin
      if (rx_valid_in)
      begin
        nxt_lfsr  = cod_lfsr;
        nxt_state = ST_IDLE;
        if ({crc_hi_ff, cod_plain} == crc_fin) // RL3
        begin
          ev[`PKH_IRQ_BODY]   = 1'b1;
          ev[`PKH_IRQ_CRC_OK] = 1'b1;
        end
        else if (keep_buffer_on_bad_check) // RL4
          ev[`PKH_IRQ_BODY] = 1'b1;
        else
          flush = 1'b1; // RL4
      end
    end
    default:
      nxt_state = ST_IDLE;
  endcase
  // Dropping the enable abandons a frame; the FIFO keeps what it has.
  if ((rx_side & ~rx_enable_in) | (~rx_side & (state_ff != ST_IDLE) & ~tx_enable_in))
    nxt_state = ST_IDLE;
end

always @(posedge clk_sys_in or negedge arst_n_in)
begin
  if (!arst_n_in)
  begin
    state_ff    <= ST_IDLE;
    cnt_ff      <= 11'h000;
    len_ff      <= 11'h000;
    crc_ff      <= 16'h0000;
    lfsr_ff     <= 9'h000;
    crc_hi_ff   <= 8'h00;
    tx_valid_ff <= 1'b0;
    tx_wide_ff  <= 1'b0;
    tx_data_ff  <= 16'h0000;
  end
  else
  begin
    state_ff    <= nxt_state;
    cnt_ff      <= nxt_cnt;
    len_ff      <= nxt_len;
    crc_ff      <= nxt_crc;
    lfsr_ff     <= nxt_lfsr;
    crc_hi_ff   <= nxt_crc_hi;
    tx_valid_ff <= nxt_tx_valid;
    tx_wide_ff  <= nxt_tx_wide;
    tx_data_ff  <= nxt_tx_data;
  end
end

// ----
// FIFO pointers
// ----
// The engine owns the port in its direction; a host access colliding with it is lost.
wire        do_push = (eng_push | host_push) & ~fifo_full;
wire        do_pop  = eng_pop | host_pop;
wire [7:0]  push_data = eng_push ? eng_data : hwdata_in[7:0];

always @(posedge clk_sys_in)
begin
  if (do_push)
    fifo_mem[wr_ptr_ff[`PKH_FIFO_AW-1:0]] <= push_data;
end

always @(posedge clk_sys_in or negedge arst_n_in)
begin
  if (!arst_n_in)
  begin
    wr_ptr_ff   <= 7'h00;
    rd_ptr_ff   <= 7'h00;
    frame_rd_ff <= 7'h00;
  end
  else
  begin
    if (do_push)
      wr_ptr_ff <= wr_ptr_ff + 7'h01;
    if (state_ff == ST_IDLE)
      frame_rd_ff <= rd_ptr_ff;
    if (flush) // RL4
      rd_ptr_ff <= wr_ptr_ff;
    else if (rewind) // RL9
      rd_ptr_ff <= frame_rd_ff;
    else if (do_pop)
      rd_ptr_ff <= rd_ptr_ff + 7'h01;
  end
end

// ----
// Register file and bus slave
// ----
always @*
begin
  case (ap_idx)
    `PKH_IDX_CFG1:     rd_val = {24'h000000, cfg1_ff};
    `PKH_IDX_CFG2:     rd_val = {24'h000000, cfg2_ff};
    `PKH_IDX_LEN_LO:   rd_val = {24'h000000, len_lo_ff};
    `PKH_IDX_OWN_ID:   rd_val = {24'h000000, own_id_ff};
    `PKH_IDX_GRP_ID:   rd_val = {24'h000000, grp_id_ff};
    `PKH_IDX_THRESH:   rd_val = {24'h000000, thr_ff};
    `PKH_IDX_IRQ_ST:   rd_val = {28'h0000000, irq_st_ff};
    `PKH_IDX_IRQ_MASK: rd_val = {28'h0000000, irq_mask_ff};
    `PKH_IDX_FIFO:     rd_val = {24'h000000, fifo_empty ? 8'h00 : fifo_head};
    `PKH_IDX_STATUS:   rd_val = {17'h00000, fill, 5'h00, buffer_level_flag,
                                 fifo_full, buffer_empty_flag};
    default:           rd_val = 32'h00000000;
  endcase
end

always @(posedge clk_sys_in or negedge arst_n_in)
begin
  if (!arst_n_in)
  begin
    cfg1_ff     <= `PKH_RST_CFG1;
    cfg2_ff     <= `PKH_RST_CFG2; // RL7 RL8
    len_lo_ff   <= `PKH_RST_LEN_LO; // RL10
    own_id_ff   <= `PKH_RST_ID;
    grp_id_ff   <= `PKH_RST_ID;
    thr_ff      <= `PKH_RST_THRESH; // RL12 RL13
    irq_st_ff   <= 4'h0;
    irq_mask_ff <= 4'h0;
    dp_wr_ff    <= 1'b0;
    dp_idx_ff   <= 8'h00;
    hrdata_ff   <= 32'h00000000;
  end
  else
  begin
    // Writes hold one wait state so a following read sees the new value.
    dp_wr_ff <= ap & hwrite_in;
    if (ap)
      dp_idx_ff <= ap_idx;
    if (ap & ~hwrite_in)
      hrdata_ff <= rd_val;
    if (dp_wr_ff)
    begin
      case (dp_idx_ff)
        `PKH_IDX_CFG1:     cfg1_ff     <= hwdata_in[7:0];
        `PKH_IDX_CFG2:     cfg2_ff     <= hwdata_in[7:0] & `PKH_WMASK_CFG2;
        `PKH_IDX_LEN_LO:   len_lo_ff   <= hwdata_in[7:0];
        `PKH_IDX_OWN_ID:   own_id_ff   <= hwdata_in[7:0];
        `PKH_IDX_GRP_ID:   grp_id_ff   <= hwdata_in[7:0];
        `PKH_IDX_THRESH:   thr_ff      <= hwdata_in[7:0] & `PKH_WMASK_THRESH;
        `PKH_IDX_IRQ_MASK: irq_mask_ff <= hwdata_in[3:0];
        default:           ;
      endcase
    end
    // A new event wins over a write-one-to-clear in the same cycle.
    irq_st_ff <= (irq_st_ff & ~(irq_wr ? hwdata_in[3:0] : 4'h0)) | ev |
                 {eng_push & fifo_full, 3'b000};
  end
end

// ----
// Outputs
// ----
assign hrdata_out       = hrdata_ff;
assign hreadyout_out    = ~dp_wr_ff;
assign hresp_out        = 1'b0;
assign tx_valid_out     = tx_valid_ff;
assign tx_wide_out      = tx_wide_ff;
assign tx_data_out      = tx_data_ff;
assign sync_len_out     = home_automation_compat ? {1'b0, sync_size_in}
                                                 : {1'b0, sync_size_in} + 4'h1; // RL14 RL8
assign buffer_level_out = buffer_level_flag;
assign buffer_empty_out = buffer_empty_flag;
assign irq_out          = |(irq_st_ff & irq_mask_ff);

endmodule

// ===== verification/pkh_checker_assertions.sv
// Port-level assertions for the packet handler, bound into its top module.
`timescale 1ns/1ps
module pkh_checker
(
  // Clock, reset and bus
  input wire        clk_sys_in,
  input wire        arst_n_in,
  input wire        hsel_in,
  input wire [1:0]  htrans_in,
  input wire        hwrite_in,
  input wire        hready_in,
  input wire [31:0] hrdata_out,
  input wire        hreadyout_out,
  input wire        hresp_out,
  // Modem and flags
  input wire        tx_enable_in,
  input wire        tx_ready_in,
  input wire        tx_valid_out,
  input wire [15:0] tx_data_out,
  input wire [2:0]  sync_size_in,
  input wire [3:0]  sync_len_out,
  input wire        buffer_level_out,
  input wire        buffer_empty_out,
  input wire        irq_out
);
  wire take = hsel_in && htrans_in[1] && hready_in;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  write_wait_a: assert property (take && hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("write wait state wrong");
  read_fast_a: assert property (take && !hwrite_in |=> hreadyout_out)
    else $error("read stalled");
  read_hold_a: assert property (!(take && !hwrite_in) |=> $stable(hrdata_out))
    else $error("read data moved");
  resp_okay_a: assert property (!hresp_out)
    else $error("error response");
  rdata_top_a: assert property (take && !hwrite_in |=> hrdata_out[31:15] == 17'h0)
    else $error("read data upper bits set");
  level_empty_a: assert property (buffer_empty_out |-> !buffer_level_out)
    else $error("level flag while empty");
  sync_len_a: assert property (sync_len_out - {1'b0, sync_size_in} <= 4'h1)
    else $error("sync length wrong");
  tx_hold_a: assert property (tx_valid_out && !tx_ready_in && tx_enable_in ##1 tx_enable_in
    |-> tx_valid_out && $stable(tx_data_out))
    else $error("transmit word dropped");
  cover property (irq_out);
  cover property (tx_valid_out && tx_ready_in);
  cover property (buffer_level_out);
endmodule
bind pkh_packet_handler pkh_checker chk_u (.*);

// ===== verification/pkh_modem_model.sv
// Modem-side partner that takes transmit words promptly or with random stalls.
`timescale 1ns/1ps
module pkh_modem_model
(
  // Clock and pacing
  input  wire  clk_sys_in,
  input  wire  slow_in,
  // Transmit handshake
  input  wire  tx_valid_in,
  output logic tx_ready_out
);
  initial tx_ready_out = 1'b0;
  // Stalls force the handler to hold words over a random number of cycles.
  always @(posedge clk_sys_in)
    tx_ready_out <= !slow_in || (tx_valid_in && ($urandom % 3 == 0));
endmodule

// ===== verification/pkh_packet_handler_tb.sv
// Self-checking bench for the packet handler with bus tasks and scoreboard queues.
`timescale 1ns/1ps
`include "pkh_map.vh"
module pkh_packet_handler_tb;
  logic        clk_sys_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, tx_en = 1'b0, rx_en = 1'b0, rx_start = 1'b0;
  logic        rx_valid = 1'b0, slow = 1'b0, rd_ph = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  sync_size = 3'h3;
  logic [15:0] rx_data = 16'h0000;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, v;
  wire  [31:0] hrdata_out;
  wire  [15:0] tx_data_out;
  wire  [3:0]  sync_len_out;
  wire         hreadyout_out, tx_ready, tx_valid_out, tx_wide_out;
  wire         buffer_level_out, buffer_empty_out, irq_out;
  logic [31:0] rq [$];
  logic [16:0] tq [$];
  int          err_count = 0, checks = 0;
  logic [7:0]  ri [7] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h10};
  logic [7:0]  rv [7] = '{8'h90, 8'h40, 8'h40, 8'h00, 8'h00, 8'h8F, 8'h00};
  logic [7:0]  wi [3] = '{8'h31, 8'h33, 8'h35};
  logic [31:0] wm [3] = '{32'h7F, 32'hFF, 32'hBF};
  logic [1:0]  lv [3] = '{2'b10, 2'b00, 2'b01};
  logic [7:0]  rc [5] = '{8'h10, 8'h18, 8'h02, 8'h02, 8'h04};
  logic [7:0]  rf [5] = '{8'h11, 8'h11, 8'h33, 8'h5A, 8'h3C};
  logic [4:0]  re = 5'b11010;
  always #5 clk_sys_in = ~clk_sys_in;
  pkh_packet_handler dut_u
  (
    .clk_sys_in, .arst_n_in, .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hreadyout_out), .hwdata_in(hwdata),
    .hrdata_out, .hreadyout_out, .hresp_out(), .tx_enable_in(tx_en), .tx_ready_in(tx_ready),
    .tx_valid_out, .tx_wide_out, .tx_data_out, .rx_enable_in(rx_en), .rx_start_in(rx_start),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data), .sync_size_in(sync_size), .sync_len_out,
    .buffer_level_out, .buffer_empty_out, .irq_out
  );
  pkh_modem_model modem_u
  (
    .clk_sys_in, .slow_in(slow), .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready)
  );
  // ----
  // Checking, bus and frame tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hold_rdy();
    @(negedge clk_sys_in);
    while (hreadyout_out !== 1'b1) @(negedge clk_sys_in);
    @(posedge clk_sys_in);
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk_sys_in);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'b00};
    hold_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    hold_rdy();
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    rq.push_back(exp);
    bus(1'b0, idx, 32'h0);
  endtask
  task automatic rx_frame(input logic [7:0] first);
    logic [7:0] w [6];
    // One idle slot after the body: the engine spends a cycle closing it before CRC words.
    w = '{first, 8'h22, 8'h33, 8'h00, 8'h00, 8'h00};
    @(posedge clk_sys_in);
    rx_start <= 1'b1;
    foreach (w[i])
    begin
      @(posedge clk_sys_in);
      rx_start <= 1'b0;
      rx_valid <= (i != 3);
      rx_data <= {8'h00, w[i]};
    end
    @(posedge clk_sys_in);
    rx_valid <= 1'b0;
  endtask
  function automatic logic [15:0] man(input logic [7:0] b);
    for (int i = 0; i < 8; i++) man[2*i +: 2] = {b[i], ~b[i]};
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(negedge clk_sys_in)
  begin
    if (rd_ph && hreadyout_out) chk("rdata", hrdata_out, rq.size() ? rq.pop_front() : 'x);
    if (hreadyout_out) rd_ph = hsel && htrans[1] && !hwrite;
    if (tx_valid_out && tx_ready)
      chk("tx", {tx_wide_out, tx_data_out}, tq.size() ? tq.pop_front() : 'x);
  end
  initial
  begin
    #400000;
    err_count++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(7831));
    v = $urandom;
    sync_size <= v[2:0];
    repeat (3) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    foreach (ri[i]) rd(ri[i], {24'h0, rv[i]});
    foreach (wi[i])
    begin
      v = $urandom;
      bus(1'b1, wi[i], v);
      rd(wi[i], v & wm[i]);
    end
    bus(1'b1, `PKH_IDX_CFG2, 32'h40);
    bus(1'b1, `PKH_IDX_OWN_ID, 32'h5A);
    bus(1'b1, `PKH_IDX_GRP_ID, 32'h3C);
    bus(1'b1, `PKH_IDX_THRESH, 32'h81);
    bus(1'b1, `PKH_IDX_IRQ_MASK, 32'hF);
    for (int k = 0; k < 3; k++)
    begin
      @(negedge clk_sys_in);
      chk("flags", {buffer_empty_out, buffer_level_out}, lv[k]);
      if (k < 2) bus(1'b1, `PKH_IDX_FIFO, 32'hA1 + k);
    end
    chk("sync", sync_len_out, sync_size + 4'h1);
    for (int k = 0; k < 3; k++) rd(`PKH_IDX_FIFO, k < 2 ? 32'hA1 + k : 32'h0);
    bus(1'b1, `PKH_IDX_THRESH, 32'h02);
    bus(1'b1, `PKH_IDX_LEN_LO, 32'h03);
    for (int c = 0; c < 2; c++)
    begin
      bus(1'b1, `PKH_IDX_CFG1, c ? 32'h20 : 32'h00);
      slow <= c[0];
      tx_en <= 1'b1;
      for (int k = 0; k < 3; k++)
      begin
        v = $urandom;
        tq.push_back(c ? {1'b1, man(v[7:0])} : {9'h0, v[7:0]});
        @(negedge clk_sys_in);
        chk("early", tx_valid_out, 1'b0);
        bus(1'b1, `PKH_IDX_FIFO, v);
      end
      for (int t = 0; t < 300 && irq_out !== 1'b1; t++) @(negedge clk_sys_in);
      chk("irq", irq_out, 1'b1);
      bus(1'b1, `PKH_IDX_IRQ_MASK, 32'h0);
      @(negedge clk_sys_in);
      chk("irq", irq_out, 1'b0);
      bus(1'b1, `PKH_IDX_IRQ_MASK, 32'hF);
      rd(`PKH_IDX_IRQ_ST, 32'h2);
      bus(1'b1, `PKH_IDX_IRQ_ST, 32'h2);
      tx_en <= 1'b0;
      @(negedge clk_sys_in);
      chk("irq", irq_out, 1'b0);
    end
    rx_en <= 1'b1;
    foreach (rc[i])
    begin
      bus(1'b1, `PKH_IDX_CFG1, rc[i]);
      rx_frame(rf[i]);
      rd(`PKH_IDX_IRQ_ST, re[i]);
      if (re[i])
      begin
        rd(`PKH_IDX_FIFO, rf[i]);
        rd(`PKH_IDX_FIFO, 32'h22);
        rd(`PKH_IDX_FIFO, 32'h33);
        bus(1'b1, `PKH_IDX_IRQ_ST, 32'h1);
      end
      @(negedge clk_sys_in);
      chk("flushed", buffer_empty_out, 1'b1);
    end
    chk("tx left", tq.size(), 32'h0);
    end_of_test();
  end
endmodule
